// File: core/cam_pkg.sv
package cam_pkg;

	localparam int NUM_MODULES = 6;

	// register port addresses
	localparam logic [7:0] ADDR_CTRL   = 8'hd8;
	localparam logic [7:0] ADDR_MODE   = 8'hd9;
	localparam logic [7:0] ADDR_CNT_LO = 8'hf9;
	localparam logic [7:0] ADDR_CNT_HI = 8'hfa;
	// per-module tables, module 0 in the low byte
	localparam logic [47:0] ADDR_MMODE_TBL = {8'hdf, 8'hde, 8'hdd, 8'hdc, 8'hdb, 8'hda};
	localparam logic [47:0] ADDR_CMPLO_TBL = {8'he1, 8'hed, 8'heb, 8'he9, 8'hfd, 8'hfb};
	localparam logic [47:0] ADDR_CMPHI_TBL = {8'he2, 8'hee, 8'hec, 8'hea, 8'hfe, 8'hfc};

	// control register fields
	localparam int CTRL_OVF_BIT = 7;
	localparam int CTRL_RUN_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// mode register fields
	localparam int MODE_IDLE_BIT = 7;
	localparam int MODE_TB_LSB   = 1;
	localparam int MODE_OVF_IE_BIT = 0;
	localparam logic [7:0] MODE_RESET   = 8'h00;
	localparam logic [7:0] MODE_RD_MASK = 8'h8f;

	// module mode register fields
	localparam int MM_WIDE_BIT  = 7;
	localparam int MM_CMPEN_BIT = 6;
	localparam int MM_MATCH_BIT = 3;
	localparam int MM_TOG_BIT   = 2;
	localparam int MM_PWM_BIT   = 1;
	localparam int MM_FLAGIE_BIT = 0;
	localparam logic [7:0] MM_RESET = 8'h00;

	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  BYTE_MAX  = 8'hff;
	localparam logic [15:0] WORD_MAX  = 16'hffff;

	// timebase dividers
	localparam int SYSCLK_DIV_SLOW = 12;
	localparam int SYSCLK_DIV_FAST = 4;
	localparam int EXT_OSC_DIV     = 8;

	typedef enum logic [2:0] {
		TB_SYSCLK_DIV12 = 3'b000,
		TB_SYSCLK_DIV4  = 3'b001,
		TB_TIMER0       = 3'b010,
		TB_ECI_FALL     = 3'b011,
		TB_SYSCLK       = 3'b100,
		TB_EXTOSC_DIV8  = 3'b101
	} cam_tb_sel_t;

endpackage

// File: core/cam_timebase.sv
module cam_timebase #(
	parameter int DIV_SLOW = cam_pkg::SYSCLK_DIV_SLOW,
	parameter int DIV_FAST = cam_pkg::SYSCLK_DIV_FAST,
	parameter int EXT_DIV  = cam_pkg::EXT_OSC_DIV
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] tb_sel,
	input  wire logic       timer0_overflow,
	input  wire logic       external_count_input,
	input  wire logic       ext_osc_in,
	output logic            tick
);
	logic [3:0] slow_q, slow_d;
	logic [3:0] fast_q, fast_d;
	logic [3:0] ext_q, ext_d;
	logic [2:0] eci_q, osc_q;
	logic       eci_fall, osc_rise;

	assign eci_fall = eci_q[2] & ~eci_q[1];
	assign osc_rise = osc_q[1] & ~osc_q[2];

	always_comb
	begin
		slow_d = (slow_q == 4'(DIV_SLOW - 1)) ? 4'h0 : slow_q + 4'h1;
		fast_d = (fast_q == 4'(DIV_FAST - 1)) ? 4'h0 : fast_q + 4'h1;
		ext_d  = ext_q;
		if (osc_rise)
			ext_d = (ext_q == 4'(EXT_DIV - 1)) ? 4'h0 : ext_q + 4'h1;
	end

	always_comb
	begin
		case (tb_sel)
			cam_pkg::TB_SYSCLK_DIV12: tick = (slow_q == 4'(DIV_SLOW - 1));
			cam_pkg::TB_SYSCLK_DIV4:  tick = (fast_q == 4'(DIV_FAST - 1));
			cam_pkg::TB_TIMER0:       tick = timer0_overflow;
			cam_pkg::TB_ECI_FALL:     tick = eci_fall;
			cam_pkg::TB_SYSCLK:       tick = 1'b1;
			cam_pkg::TB_EXTOSC_DIV8:  tick = osc_rise && (ext_q == 4'(EXT_DIV - 1));
			default:                  tick = 1'b0;
		endcase
	end

	// bit 0 only feeds bit 1; edges are taken from the settled stages
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			slow_q <= 4'h0;
			fast_q <= 4'h0;
			ext_q  <= 4'h0;
			eci_q  <= 3'h0;
			osc_q  <= 3'h0;
		end
		else
		begin
			slow_q <= slow_d;
			fast_q <= fast_d;
			ext_q  <= ext_d;
			eci_q  <= {eci_q[1:0], external_count_input};
			osc_q  <= {osc_q[1:0], ext_osc_in};
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_sysclk_tick_each: assert property (tb_sel == cam_pkg::TB_SYSCLK |-> tick)
		else $error("system clock timebase missed a tick");
	chk_reserved_no_tick: assert property (tb_sel[2:1] == 2'b11 |-> !tick)
		else $error("reserved timebase produced a tick");
	chk_div4_spacing: assert property (tb_sel == cam_pkg::TB_SYSCLK_DIV4 && tick
		|=> (!tick || tb_sel != cam_pkg::TB_SYSCLK_DIV4) [*3])
		else $error("divide by four tick spacing wrong");

endmodule // cam_timebase

// File: core/cam_channel.sv
module cam_channel (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic [15:0] cnt_next,
	input  wire logic        low_wrap,
	input  wire logic        full_wrap,
	input  wire logic        cmp_en,
	input  wire logic        match_en,
	input  wire logic        tog_en,
	input  wire logic        pwm_en,
	input  wire logic        wide_sel,
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [7:0]  wdata,
	output logic [7:0]       cmp_lo,
	output logic [7:0]       cmp_hi,
	output logic             pin,
	output logic             event_hit
);
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic       pin_q, pin_d;
	logic       hso, freq, pwm8, pwm16, m16, m8;
	logic [7:0] tgt8;

	assign hso   = cmp_en & match_en & tog_en & ~pwm_en;
	assign freq  = cmp_en & tog_en & pwm_en;
	assign pwm8  = cmp_en & pwm_en & ~tog_en & ~wide_sel;
	assign pwm16 = cmp_en & pwm_en & ~tog_en & wide_sel;

	// at the wrap the reloaded value is compared, so a high byte of zero gives full duty
	assign tgt8 = (pwm8 & low_wrap) ? hi_q : lo_q;
	assign m16  = tick & (cnt_next == {hi_q, lo_q});
	assign m8   = tick & (cnt_next[7:0] == tgt8);

	always_comb
	begin
		lo_d  = lo_q;
		hi_d  = hi_q;
		pin_d = pin_q;
		if (hso && m16)
			pin_d = ~pin_q;
		if (freq && m8)
		begin
			pin_d = ~pin_q;
			lo_d  = lo_q + hi_q;
		end
		if (pwm8)
		begin
			if (low_wrap)
			begin
				lo_d  = hi_q;
				pin_d = 1'b0;
			end
			if (m8)
				pin_d = 1'b1;
		end
		if (pwm16)
		begin
			if (full_wrap)
				pin_d = 1'b0;
			if (m16)
				pin_d = 1'b1;
		end
		// software write wins over hardware stepping
		if (wr_lo)
			lo_d = wdata;
		if (wr_hi)
			hi_d = wdata;
	end

	assign event_hit = cmp_en & (pwm_en ? (wide_sel ? m16 : m8) : (match_en & m16));
	assign cmp_lo = lo_q;
	assign cmp_hi = hi_q;
	assign pin    = pin_q;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lo_q  <= cam_pkg::BYTE_ZERO;
			hi_q  <= cam_pkg::BYTE_ZERO;
			pin_q <= 1'b0;
		end
		else
		begin
			lo_q  <= lo_d;
			hi_q  <= hi_d;
			pin_q <= pin_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_hso_pin_toggle: assert property (hso && m16 |=> pin_q != $past(pin_q))
		else $error("high speed output did not toggle on match");
	chk_freq_lo_step: assert property (freq && m8 && !wr_lo |=> lo_q == 8'($past(lo_q) + $past(hi_q)))
		else $error("frequency output compare step wrong");
	chk_pwm8_reload: assert property (pwm8 && low_wrap && !wr_lo |=> lo_q == $past(hi_q))
		else $error("pwm8 compare low byte not reloaded");
	chk_pwm8_low_edge: assert property (pwm8 && low_wrap && !m8 |=> !pin_q)
		else $error("pwm8 output not low after wrap");
	chk_pwm16_high_edge: assert property (pwm16 && m16 |=> pin_q)
		else $error("pwm16 output not high after match");
	chk_pwm16_low_edge: assert property (pwm16 && full_wrap && !m16 |=> !pin_q)
		else $error("pwm16 output not low after overflow");
	cov_freq_toggle: cover property (freq && m8 ##1 !m8 [*2] ##1 freq && m8);
	cov_pwm8_cycle: cover property (pwm8 && m8 && !low_wrap);

endmodule // cam_channel

// File: core/cam_top.sv
// Notes on behaviour
// - high speed mode toggles pin on match
// - toggle, match, comparator bits pick high speed
// - low write clears, high write sets comparator
// - frequency match toggles, adds high to low
// - comparator, toggle, pwm bits pick frequency
// - high byte zero means 256 clocks
// - pwm8 high on match, low on wrap
// - pwm8 reloads low from high at wrap
// - comparator, pwm, not wide pick pwm8
// - pwm8 high fraction is 256 minus high
// - pwm16 high on match, low on overflow
// - comparator, pwm, wide bits pick pwm16
// - pwm16 high fraction 65536 minus compare
// - overflow flag set by hardware, software clears
// - overflow request needs enable and flag
// - run bit stops or starts counter
// - match or capture sets module flag
// - idle bit suspends array in idle
// - three select bits choose counter timebase
// - low read snapshots high byte
// - module flag enable gates its request
module cam_top #(
	parameter int NUM_MODULES = cam_pkg::NUM_MODULES
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic                   sfr_rd,
	input  wire logic [7:0]             sfr_wdata,
	output logic [7:0]                  sfr_rdata,
	input  wire logic                   cpu_idle,
	input  wire logic                   timer0_overflow,
	input  wire logic                   external_count_input,
	input  wire logic                   ext_osc_in,
	input  wire logic [NUM_MODULES-1:0] capture_event,
	output logic [NUM_MODULES-1:0]      module_output_pin,
	output logic                        irq
);
	logic                   ovf_flag_q, ovf_flag_d;
	logic                   run_q, run_d;
	logic [NUM_MODULES-1:0] flag_q, flag_d;
	logic                   idle_sus_q, idle_sus_d;
	logic [2:0]             tb_q, tb_d;
	logic                   ovf_ie_q, ovf_ie_d;
	logic [7:0]             mm_q [NUM_MODULES];
	logic [7:0]             mm_d [NUM_MODULES];
	logic [15:0]            cnt_q, cnt_d;
	logic [7:0]             snap_q, snap_d;
	logic [7:0]             rdata_q, rdata_d;

	logic                   tb_tick, step, low_wrap, full_wrap;
	logic [NUM_MODULES-1:0] wr_lo, wr_hi, wr_mm, hit;
	logic [7:0]             cmp_lo [NUM_MODULES];
	logic [7:0]             cmp_hi [NUM_MODULES];

	logic wr_ctrl, wr_mode, wr_cnt_lo, wr_cnt_hi, rd_cnt_lo;

	assign wr_ctrl   = sfr_wr && (sfr_addr == cam_pkg::ADDR_CTRL);
	assign wr_mode   = sfr_wr && (sfr_addr == cam_pkg::ADDR_MODE);
	assign wr_cnt_lo = sfr_wr && (sfr_addr == cam_pkg::ADDR_CNT_LO);
	assign wr_cnt_hi = sfr_wr && (sfr_addr == cam_pkg::ADDR_CNT_HI);
	assign rd_cnt_lo = sfr_rd && (sfr_addr == cam_pkg::ADDR_CNT_LO);

	cam_timebase u_timebase (
		.sys_clk              (sys_clk),
		.rst                  (rst),
		.tb_sel               (tb_q),
		.timer0_overflow      (timer0_overflow),
		.external_count_input (external_count_input),
		.ext_osc_in           (ext_osc_in),
		.tick                 (tb_tick)
	);

	assign step      = tb_tick & run_q & ~(idle_sus_q & cpu_idle);
	assign low_wrap  = step & (cnt_q[7:0] == cam_pkg::BYTE_MAX);
	assign full_wrap = step & (cnt_q == cam_pkg::WORD_MAX);

	always_comb
	begin
		cnt_d = cnt_q;
		if (step)
			cnt_d = cnt_q + 16'h0001;
		// a write lands over a simultaneous step
		if (wr_cnt_lo)
			cnt_d[7:0] = sfr_wdata;
		if (wr_cnt_hi)
			cnt_d[15:8] = sfr_wdata;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_MODULES; gi++)
		begin : g_mod
			assign wr_lo[gi] = sfr_wr && (sfr_addr == cam_pkg::ADDR_CMPLO_TBL[gi*8 +: 8]);
			assign wr_hi[gi] = sfr_wr && (sfr_addr == cam_pkg::ADDR_CMPHI_TBL[gi*8 +: 8]);
			assign wr_mm[gi] = sfr_wr && (sfr_addr == cam_pkg::ADDR_MMODE_TBL[gi*8 +: 8]);

			// comparator sees the count the counter is about to take
			cam_channel u_chan (
				.sys_clk   (sys_clk),
				.rst       (rst),
				.tick      (step),
				.cnt_next  (cnt_q + 16'h0001),
				.low_wrap  (low_wrap),
				.full_wrap (full_wrap),
				.cmp_en    (mm_q[gi][cam_pkg::MM_CMPEN_BIT]),
				.match_en  (mm_q[gi][cam_pkg::MM_MATCH_BIT]),
				.tog_en    (mm_q[gi][cam_pkg::MM_TOG_BIT]),
				.pwm_en    (mm_q[gi][cam_pkg::MM_PWM_BIT]),
				.wide_sel  (mm_q[gi][cam_pkg::MM_WIDE_BIT]),
				.wr_lo     (wr_lo[gi]),
				.wr_hi     (wr_hi[gi]),
				.wdata     (sfr_wdata),
				.cmp_lo    (cmp_lo[gi]),
				.cmp_hi    (cmp_hi[gi]),
				.pin       (module_output_pin[gi]),
				.event_hit (hit[gi])
			);
		end
	endgenerate

	always_comb
	begin
		run_d      = run_q;
		idle_sus_d = idle_sus_q;
		tb_d       = tb_q;
		ovf_ie_d   = ovf_ie_q;
		ovf_flag_d = ovf_flag_q;
		flag_d     = flag_q;
		if (wr_ctrl)
		begin
			ovf_flag_d = sfr_wdata[cam_pkg::CTRL_OVF_BIT];
			run_d      = sfr_wdata[cam_pkg::CTRL_RUN_BIT];
			flag_d     = sfr_wdata[NUM_MODULES-1:0];
		end
		if (wr_mode)
		begin
			idle_sus_d = sfr_wdata[cam_pkg::MODE_IDLE_BIT];
			tb_d       = sfr_wdata[cam_pkg::MODE_TB_LSB +: 3];
			ovf_ie_d   = sfr_wdata[cam_pkg::MODE_OVF_IE_BIT];
		end
		if (full_wrap)
			ovf_flag_d = 1'b1;
		flag_d = flag_d | hit | capture_event;
		for (int i = 0; i < NUM_MODULES; i++)
		begin
			mm_d[i] = wr_mm[i] ? sfr_wdata : mm_q[i];
			if (wr_lo[i])
				mm_d[i][cam_pkg::MM_CMPEN_BIT] = 1'b0;
			if (wr_hi[i])
				mm_d[i][cam_pkg::MM_CMPEN_BIT] = 1'b1;
		end
	end

	always_comb
	begin
		snap_d  = rd_cnt_lo ? cnt_q[15:8] : snap_q;
		rdata_d = rdata_q;
		if (sfr_rd)
		begin
			rdata_d = cam_pkg::BYTE_ZERO;
			case (sfr_addr)
				cam_pkg::ADDR_CTRL:   rdata_d = {ovf_flag_q, run_q, {(6 - NUM_MODULES){1'b0}}, flag_q};
				cam_pkg::ADDR_MODE:   rdata_d = {idle_sus_q, 3'b000, tb_q, ovf_ie_q} & cam_pkg::MODE_RD_MASK;
				cam_pkg::ADDR_CNT_LO: rdata_d = cnt_q[7:0];
				cam_pkg::ADDR_CNT_HI: rdata_d = snap_q;
				default:
				begin
					for (int i = 0; i < NUM_MODULES; i++)
					begin
						if (sfr_addr == cam_pkg::ADDR_MMODE_TBL[i*8 +: 8])
							rdata_d = mm_q[i];
						if (sfr_addr == cam_pkg::ADDR_CMPLO_TBL[i*8 +: 8])
							rdata_d = cmp_lo[i];
						if (sfr_addr == cam_pkg::ADDR_CMPHI_TBL[i*8 +: 8])
							rdata_d = cmp_hi[i];
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 16'h0000;
		end
		else
		begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ovf_flag_q <= cam_pkg::CTRL_RESET[cam_pkg::CTRL_OVF_BIT];
			run_q      <= cam_pkg::CTRL_RESET[cam_pkg::CTRL_RUN_BIT];
			flag_q     <= cam_pkg::CTRL_RESET[NUM_MODULES-1:0];
		end
		else
		begin
			ovf_flag_q <= ovf_flag_d;
			run_q      <= run_d;
			flag_q     <= flag_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			idle_sus_q <= cam_pkg::MODE_RESET[cam_pkg::MODE_IDLE_BIT];
			tb_q       <= cam_pkg::MODE_RESET[cam_pkg::MODE_TB_LSB +: 3];
			ovf_ie_q   <= cam_pkg::MODE_RESET[cam_pkg::MODE_OVF_IE_BIT];
		end
		else
		begin
			idle_sus_q <= idle_sus_d;
			tb_q       <= tb_d;
			ovf_ie_q   <= ovf_ie_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUM_MODULES; i++)
				mm_q[i] <= cam_pkg::MM_RESET;
		end
		else
		begin
			for (int i = 0; i < NUM_MODULES; i++)
				mm_q[i] <= mm_d[i];
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			snap_q  <= cam_pkg::BYTE_ZERO;
			rdata_q <= cam_pkg::BYTE_ZERO;
		end
		else
		begin
			snap_q  <= snap_d;
			rdata_q <= rdata_d;
		end
	end

	logic [NUM_MODULES-1:0] flag_ie;
	always_comb
	begin
		for (int i = 0; i < NUM_MODULES; i++)
			flag_ie[i] = mm_q[i][cam_pkg::MM_FLAGIE_BIT];
	end

	assign irq       = (ovf_flag_q & ovf_ie_q) | (|(flag_q & flag_ie));
	assign sfr_rdata = rdata_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_ovf_flag_set: assert property (full_wrap |=> ovf_flag_q && cnt_q[7:0] == 8'h00)
		else $error("overflow flag not set at counter wrap");
	chk_ovf_flag_sticky: assert property (ovf_flag_q && !wr_ctrl |=> ovf_flag_q)
		else $error("overflow flag cleared without software");
	chk_ovf_irq_gate: assert property (flag_q == '0 |-> irq == (ovf_flag_q && ovf_ie_q))
		else $error("overflow request not gated by enable");
	chk_flag_irq_gate: assert property (!ovf_ie_q && ((flag_q & flag_ie) == '0) |-> !irq)
		else $error("module request raised while masked");
	chk_run_hold: assert property (!run_q && !wr_cnt_lo && !wr_cnt_hi |=> cnt_q == $past(cnt_q))
		else $error("counter moved while stopped");
	chk_cnt_step: assert property (step && !wr_cnt_lo && !wr_cnt_hi |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not advance by one on a step");
	chk_idle_hold: assert property (idle_sus_q && cpu_idle && !wr_cnt_lo && !wr_cnt_hi
		|=> $stable(cnt_q))
		else $error("counter moved during suspended idle");
	chk_lo_clears_cmpen: assert property (wr_lo[0] && !wr_hi[0] |=> !mm_q[0][cam_pkg::MM_CMPEN_BIT])
		else $error("compare low write left comparator enabled");
	chk_hi_sets_cmpen: assert property (wr_hi[0] |=> mm_q[0][cam_pkg::MM_CMPEN_BIT])
		else $error("compare high write did not enable comparator");
	chk_flag_on_hit: assert property (hit[0] |=> flag_q[0])
		else $error("module flag not set on match");
	chk_snapshot_read: assert property (rd_cnt_lo ##1 !sfr_rd
		##1 (sfr_rd && sfr_addr == cam_pkg::ADDR_CNT_HI) |=> sfr_rdata == $past(cnt_q[15:8], 3))
		else $error("high byte read missed snapshot");
	cov_counter_wrap: cover property (full_wrap);
	cov_hso_pin_rise: cover property ($rose(module_output_pin[0]));
	cov_irq_raised: cover property ($rose(irq));

endmodule // cam_top

// File: sim/cam_cpu_model.sv
module cam_cpu_model (
	input  wire logic       sys_clk,
	output logic [7:0]      sfr_addr,
	output logic            sfr_wr,
	output logic            sfr_rd,
	output logic [7:0]      sfr_wdata,
	input  wire logic [7:0] sfr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end

	// released bus shows inverted values, never the last one
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
	endtask

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		#1;
		d = sfr_rdata;
	endtask

	task automatic cmp_write(input int m, input logic [15:0] v, output logic [7:0] mid);
		sfr_write(cam_pkg::ADDR_CMPLO_TBL[8*m +: 8], v[7:0]);
		sfr_read(cam_pkg::ADDR_MMODE_TBL[8*m +: 8], mid);
		sfr_write(cam_pkg::ADDR_CMPHI_TBL[8*m +: 8], v[15:8]);
	endtask

	task automatic flags_clear(input logic run);
		sfr_write(cam_pkg::ADDR_CTRL, {1'b0, run, 6'h00});
	endtask
endmodule // cam_cpu_model

// File: sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, rst, cpu_idle, timer0_overflow, external_count_input, ext_osc_in;
	logic [5:0]  capture_event, module_output_pin;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic        sfr_wr, sfr_rd, irq;
	int          fail_count, tests_run, phase;
	logic [31:0] seed;

	cam_top cam_top_i (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
		.external_count_input(external_count_input), .ext_osc_in(ext_osc_in), .capture_event(capture_event),
		.module_output_pin(module_output_pin), .irq(irq));
	cam_cpu_model cam_cpu_model_i (.sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		cpu_idle = 1'b0;
		capture_event = 6'h00;
		timer0_overflow = 1'b0;
		external_count_input = 1'b1;
		ext_osc_in = 1'b0;
		phase = 0;
		fail_count = 0;
		tests_run = 0;
		seed = 32'h368b;
	end
	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
	begin
		phase <= phase + 1;
		timer0_overflow <= (phase % 6 == 0);
		external_count_input <= ((phase / 4) % 2 == 0);
		ext_osc_in <= ((phase / 2) % 2 == 1);
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cam_cpu_model_i.sfr_write(a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		cam_cpu_model_i.sfr_read(a, d);
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
		tests_run++;
		if ((got & mask) !== (exp & mask))
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic check_cnt(input logic [15:0] got, input int lo, input int hi);
		logic signed [31:0] g;
		g = {16'h0000, got};
		tests_run++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	task automatic read_cnt(output logic [15:0] c);
		rd(cam_pkg::ADDR_CNT_LO, c[7:0]);
		rd(cam_pkg::ADDR_CNT_HI, c[15:8]);
	endtask

	// per-module reference, steps through each counter value
	task automatic model(input int kind, input int s, input int n, inout int lo, input int hi,
		output int pin, output int hit);
		int v;
		pin = 0;
		hit = 0;
		for (int i = 1; i <= n; i++)
		begin
			v = (s + i) % 65536;
			case (kind)
				0: if (v == hi * 256 + lo)
				begin
					pin ^= 1;
					hit = 1;
				end
				1: if (v % 256 == lo)
				begin
					pin ^= 1;
					lo = (lo + hi) % 256;
				end
				2:
				begin
					if (v % 256 == 0)
					begin
						pin = 0;
						lo = hi;
					end
					if (v % 256 == lo)
						pin = 1;
				end
				default: if (v == hi * 256 + lo)
				begin
					pin = 1;
					hit = 1;
				end
				else if (v == 0)
					pin = 0;
			endcase
		end
	endtask

	task automatic reset_test();
		logic [7:0] d;
		do_reset();
		rd(cam_pkg::ADDR_CTRL, d);
		check8(d, cam_pkg::CTRL_RESET, 8'hff);
		rd(cam_pkg::ADDR_MODE, d);
		check8(d, cam_pkg::MODE_RESET, 8'hff);
		rd(8'h80, d);
		check8(d, 8'h00, 8'hff);
		wr(cam_pkg::ADDR_MODE, 8'hff);
		rd(cam_pkg::ADDR_MODE, d);
		check8(d, cam_pkg::MODE_RD_MASK, 8'hff);
		$display("reset and map test done");
	endtask

	task automatic timebase_test();
		logic [7:0]  md [10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h88, 8'h08};
		logic        idl [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
		int          ex [10] = '{40, 120, 80, 60, 480, 15, 0, 0, 0, 480};
		logic [15:0] c, c2;
		for (int i = 0; i < 10; i++)
		begin
			wr(cam_pkg::ADDR_MODE, md[i]);
			cpu_idle <= idl[i];
			wr(cam_pkg::ADDR_CNT_LO, 8'h00);
			wr(cam_pkg::ADDR_CNT_HI, 8'h00);
			wr(cam_pkg::ADDR_CTRL, 8'h40);
			repeat (480) @(posedge sys_clk);
			wr(cam_pkg::ADDR_CTRL, 8'h00);
			read_cnt(c);
			check_cnt(c, ex[i] - 2, ex[i] + 2);
			repeat (20) @(posedge sys_clk);
			read_cnt(c2);
			check_cnt(c2, c, c);
		end
		cpu_idle <= 1'b0;
		$display("timebase test done");
	endtask

	task automatic round_test();
		logic [7:0]  mm [4] = '{8'h4c, 8'h46, 8'h42, 8'hc2};
		logic [7:0]  d;
		logic [15:0] c;
		int          s, n, steps, k, pin, hit, cf, l;
		int          lo [6], hi [6];
		logic [7:0]  fl;
		do_reset();
		cpu_idle <= 1'b1;
		seed = lfsr(seed);
		s = 'hff00 + seed[7:0];
		n = 64 + seed[16:8];
		for (int m = 0; m < 6; m++)
		begin
			k = (m < 4) ? m : m - 3;
			seed = lfsr(seed);
			lo[m] = seed[7:0];
			hi[m] = (m > 3) ? 0 : (k == 1 || k == 2) ? seed[15:8] : (seed[8] ? 255 : 0);
			wr(cam_pkg::ADDR_MMODE_TBL[8*m +: 8], mm[k]);
			cam_cpu_model_i.cmp_write(m, 16'(hi[m] * 256 + lo[m]), d);
			check8(d, 8'h00, 8'h40);
			rd(cam_pkg::ADDR_MMODE_TBL[8*m +: 8], d);
			check8(d, mm[k], 8'hff);
		end
		wr(cam_pkg::ADDR_MODE, 8'h89);
		wr(cam_pkg::ADDR_CNT_LO, 8'(s));
		wr(cam_pkg::ADDR_CNT_HI, 8'(s >> 8));
		wr(cam_pkg::ADDR_CTRL, 8'h40);
		cpu_idle <= 1'b0;
		repeat (n) @(posedge sys_clk);
		cpu_idle <= 1'b1;
		repeat (2) @(posedge sys_clk);
		read_cnt(c);
		steps = (int'(c) - s + 65536) % 65536;
		cf = (s + steps >= 65536);
		fl = 8'h00;
		for (int m = 0; m < 6; m++)
		begin
			k = (m < 4) ? m : m - 3;
			l = lo[m];
			model(k, s, steps, l, hi[m], pin, hit);
			check_bit(module_output_pin[m], 1'(pin));
			rd(cam_pkg::ADDR_CMPLO_TBL[8*m +: 8], d);
			check8(d, 8'(l), 8'hff);
			if (m == 0 || m == 3)
				fl[m] = 1'(hit);
		end
		rd(cam_pkg::ADDR_CTRL, d);
		check8(d, {1'(cf), 1'b1, 6'h00} | fl, 8'hc9);
		check_bit(irq, 1'(cf));
		cam_cpu_model_i.flags_clear(1'b1);
		@(negedge sys_clk);
		check_bit(irq, 1'b0);
		wr(cam_pkg::ADDR_MMODE_TBL[7:0], 8'h4d);
		@(posedge sys_clk);
		capture_event <= 6'h01;
		@(posedge sys_clk);
		capture_event <= 6'h00;
		@(negedge sys_clk);
		check_bit(irq, 1'b1);
		rd(cam_pkg::ADDR_CTRL, d);
		check8(d, 8'h41, 8'hff);
		$display("round test done, start %h steps %0d", s[15:0], steps);
	endtask

	// new compare written in step with the match request
	task automatic duty_test();
		logic [7:0] d;
		do_reset();
		wr(cam_pkg::ADDR_MODE, 8'h08);
		wr(cam_pkg::ADDR_MMODE_TBL[31:24], 8'hc3);
		cam_cpu_model_i.cmp_write(3, 16'hff80, d);
		check8(d, 8'h00, 8'h40);
		wr(cam_pkg::ADDR_CNT_HI, 8'hff);
		wr(cam_pkg::ADDR_CTRL, 8'h40);
		for (int t = 0; t < 400 && irq !== 1'b1; t++)
			@(negedge sys_clk);
		check_bit(module_output_pin[3], 1'b1);
		cam_cpu_model_i.cmp_write(3, 16'h0040, d);
		cam_cpu_model_i.flags_clear(1'b1);
		repeat (150) @(posedge sys_clk);
		check_bit(module_output_pin[3], 1'b0);
		for (int t = 0; t < 400 && irq !== 1'b1; t++)
			@(negedge sys_clk);
		check_bit(module_output_pin[3], 1'b1);
		rd(cam_pkg::ADDR_CTRL, d);
		check8(d, 8'hc8, 8'hff);
		$display("duty test done");
	endtask

	initial
	begin
		reset_test();
		timebase_test();
		repeat (3) round_test();
		duty_test();
		print_verdict();
	end

	// span well beyond the ten timebase windows and three rounds
	initial
	begin
		#200000;
		fail_count++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		print_verdict();
	end
endmodule // tb_top
